// ### rtl/vst_pkg.sv
// Constants, timing counts and phase encoding for the VGA sync timing generator.
// Assumes a single 100 MHz clock from which a pixel enable is divided down.
// Operation
// - 640 visible pixels by 480 visible rows.
// - Pixel rate near 25.175 MHz, one per period.
// - Line 31.77 us; sync 3.77, back 1.89 blank.
// - 640 pixels in 25.17 us; front 0.94 blank.
// - Frame 16.6 ms; sync 64 us, back 1.02 ms.
// - 480 rows in 15.25 ms; front 0.35 ms.
// - Frame starts top-left, pixels left to right.
// - One horizontal sync pulse per row.
// - Vertical sync after bottom row, back to origin.
// - Track position; colour only while on screen.
// - Red, green, blue driven per pixel slot.
package vst_pkg;

    localparam int unsigned CLK_FREQ_KHZ = 100000;
    localparam int unsigned CLK_NS       = 10;
    localparam int unsigned PIX_FREQ_KHZ = 25175;
    // The 100 MHz clock cannot hit 25.175 MHz exactly; the nearest divider gives 25 MHz.
    localparam int unsigned PIX_DIV      = (CLK_FREQ_KHZ + PIX_FREQ_KHZ / 2) / PIX_FREQ_KHZ;
    localparam int unsigned PIX_NS       = CLK_NS * PIX_DIV;

    localparam int unsigned H_LINE_NS  = 31770;
    localparam int unsigned H_SYNC_NS  = 3770;
    localparam int unsigned H_BACK_NS  = 1890;
    localparam int unsigned H_VIS_NS   = 25170;
    localparam int unsigned H_FRONT_NS = 940;

    localparam int unsigned H_VIS_PIX   = 640;
    localparam int unsigned H_SYNC_PIX  = (H_SYNC_NS + PIX_NS / 2) / PIX_NS;
    localparam int unsigned H_BACK_PIX  = (H_BACK_NS + PIX_NS / 2) / PIX_NS;
    localparam int unsigned H_FRONT_PIX = (H_FRONT_NS + PIX_NS / 2) / PIX_NS;
    localparam int unsigned H_LINE_PIX  = H_SYNC_PIX + H_BACK_PIX + H_VIS_PIX + H_FRONT_PIX;
    localparam int unsigned LINE_NS     = H_LINE_PIX * PIX_NS;

    localparam int unsigned V_FRAME_NS = 16600000;
    localparam int unsigned V_SYNC_NS  = 64000;
    localparam int unsigned V_BACK_NS  = 1020000;
    localparam int unsigned V_VIS_NS   = 15250000;
    localparam int unsigned V_FRONT_NS = 350000;

    localparam int unsigned V_VIS_LINES   = 480;
    localparam int unsigned V_SYNC_LINES  = (V_SYNC_NS + LINE_NS / 2) / LINE_NS;
    localparam int unsigned V_BACK_LINES  = (V_BACK_NS + LINE_NS / 2) / LINE_NS;
    localparam int unsigned V_FRONT_LINES = (V_FRONT_NS + LINE_NS / 2) / LINE_NS;

    localparam int unsigned CNT_W        = 10;
    localparam int unsigned COLOR_W      = 1;
    localparam int unsigned FIFO_DEPTH   = 8;
    localparam logic        SYNC_IDLE    = 1'b1;

    typedef enum logic [3:0] {
        VST_PH_SYNC  = 4'h1,
        VST_PH_BACK  = 4'h2,
        VST_PH_VIS   = 4'h4,
        VST_PH_FRONT = 4'h8
    } vst_phase_t;

endpackage : vst_pkg

// ### rtl/vst_stream_if.sv
// Valid/ready word stream between the generator and its pixel FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface vst_stream_if #(
    parameter int W = 3
);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : vst_stream_if
`default_nettype wire

// ### rtl/vst_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module vst_fifo #(
    parameter int W     = 3,
    parameter int DEPTH = 8
) (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    vst_stream_if.snk   wr,
    vst_stream_if.src   rd
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [W-1:0]     mem_reg [DEPTH];
    logic [W-1:0]     mem_next [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             wr_fire;
    logic             rd_fire;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction : ptr_inc

    assign wr.ready = (cnt_reg != CNT_W'(DEPTH));
    assign rd.valid = (cnt_reg != '0);
    assign rd.data  = mem_reg[rd_ptr_reg];
    assign wr_fire  = wr.valid & wr.ready;
    assign rd_fire  = rd.valid & rd.ready;

    always_comb begin
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        cnt_next    = cnt_reg;
        if (wr_fire) begin
            mem_next[wr_ptr_reg] = wr.data;
            wr_ptr_next          = ptr_inc(wr_ptr_reg);
        end
        if (rd_fire) begin
            rd_ptr_next = ptr_inc(rd_ptr_reg);
        end
        if (wr_fire && !rd_fire) begin
            cnt_next = cnt_reg + CNT_W'(1);
        end else if (rd_fire && !wr_fire) begin
            cnt_next = cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        mem_reg <= mem_next;
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
        end
    end
endmodule : vst_fifo
`default_nettype wire

// ### rtl/vst_sync_gen.sv
// VGA sync timing generator: beam position, active-low syncs and colour outputs.
// Assumes a pixel source that streams colour words in raster order, origin first.
`timescale 1ns/1ps
`default_nettype none
module vst_sync_gen #(
    parameter int COLOR_W    = vst_pkg::COLOR_W,
    parameter int FIFO_DEPTH = vst_pkg::FIFO_DEPTH
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic [3*COLOR_W-1:0]      pix_data_i,
    input  wire logic                      pix_valid_i,
    output logic                           pix_ready_o,
    output logic                           hsync_n_o,
    output logic                           vsync_n_o,
    output logic [COLOR_W-1:0]             red_o,
    output logic [COLOR_W-1:0]             green_o,
    output logic [COLOR_W-1:0]             blue_o,
    output logic [vst_pkg::CNT_W-1:0]      h_pos_o,
    output logic [vst_pkg::CNT_W-1:0]      v_pos_o,
    output logic                           active_o,
    output logic                           frame_start_o,
    output logic                           underrun_o
);
    localparam int DW  = 3 * COLOR_W;
    localparam int CW  = vst_pkg::CNT_W;
    localparam int DVW = $clog2(vst_pkg::PIX_DIV + 1);

    // Raster per line in pixels: sync, back porch, 640 visible, front porch;
    // per frame in lines: sync, back porch, 480 visible, front porch. Each
    // pixel lasts PIX_DIV clocks of the one input clock, so the pixel rate is
    // the nearest whole fraction of the clock, and the line and frame periods
    // come out slightly longer than nominal while the visible extent is exact.
    // The FIFO only decouples the colour source from the raster: there is no
    // frame marker in the data, so a source that loses count after an
    // underrun stays out of step until it realigns on frame_start_o.

    vst_stream_if #(.W(DW)) in_if ();
    vst_stream_if #(.W(DW)) out_if ();

    assign in_if.data  = pix_data_i;
    assign in_if.valid = pix_valid_i;
    assign pix_ready_o = in_if.ready;

    vst_fifo #(
        .W     (DW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_n_i),
        .wr      (in_if),
        .rd      (out_if)
    );

    // Length of a phase in pixels (horizontal) or in lines (vertical).
    function automatic logic [CW-1:0] phase_len(input logic vert, input vst_pkg::vst_phase_t ph);
        case (ph)
            vst_pkg::VST_PH_SYNC:  phase_len = vert ? CW'(vst_pkg::V_SYNC_LINES)
                                                    : CW'(vst_pkg::H_SYNC_PIX);
            vst_pkg::VST_PH_BACK:  phase_len = vert ? CW'(vst_pkg::V_BACK_LINES)
                                                    : CW'(vst_pkg::H_BACK_PIX);
            vst_pkg::VST_PH_VIS:   phase_len = vert ? CW'(vst_pkg::V_VIS_LINES)
                                                    : CW'(vst_pkg::H_VIS_PIX);
            vst_pkg::VST_PH_FRONT: phase_len = vert ? CW'(vst_pkg::V_FRONT_LINES)
                                                    : CW'(vst_pkg::H_FRONT_PIX);
            default:               phase_len = CW'(1);
        endcase
    endfunction : phase_len

    function automatic vst_pkg::vst_phase_t phase_step(input vst_pkg::vst_phase_t ph);
        case (ph)
            vst_pkg::VST_PH_SYNC:  phase_step = vst_pkg::VST_PH_BACK;
            vst_pkg::VST_PH_BACK:  phase_step = vst_pkg::VST_PH_VIS;
            vst_pkg::VST_PH_VIS:   phase_step = vst_pkg::VST_PH_FRONT;
            vst_pkg::VST_PH_FRONT: phase_step = vst_pkg::VST_PH_SYNC;
            default:               phase_step = vst_pkg::VST_PH_SYNC;
        endcase
    endfunction : phase_step

    // Last count of a phase. Both counters share it, so the wrap point is
    // decoded the same way for lines and for frames.
    function automatic logic phase_end(input logic [CW-1:0] cnt, input logic vert,
                                       input vst_pkg::vst_phase_t ph);
        phase_end = (cnt == phase_len(vert, ph) - CW'(1));
    endfunction : phase_end

    logic [DVW-1:0]      div_reg, div_next;
    vst_pkg::vst_phase_t hph_reg, hph_next;
    vst_pkg::vst_phase_t vph_reg, vph_next;
    logic [CW-1:0]       hcnt_reg, hcnt_next;
    logic [CW-1:0]       vcnt_reg, vcnt_next;
    logic                hsync_reg, hsync_next;
    logic                vsync_reg, vsync_next;
    logic [DW-1:0]       rgb_reg, rgb_next;
    logic [CW-1:0]       hpos_reg, hpos_next;
    logic [CW-1:0]       vpos_reg, vpos_next;
    logic                act_reg, act_next;
    logic                fs_reg, fs_next;
    logic                und_reg, und_next;
    logic                pix_en;
    logic                vis;

    assign pix_en = (div_reg == DVW'(vst_pkg::PIX_DIV - 1));
    assign vis = (hph_reg == vst_pkg::VST_PH_VIS) && (vph_reg == vst_pkg::VST_PH_VIS);
    // At most one colour word leaves the FIFO per visible pixel, never during blanking.
    assign out_if.ready = pix_en & vis;

    // Beam state: pixel divider, phases and counters.
    always_comb begin
        div_next  = pix_en ? '0 : div_reg + DVW'(1);
        hph_next  = hph_reg;
        vph_next  = vph_reg;
        hcnt_next = hcnt_reg;
        vcnt_next = vcnt_reg;
        if (pix_en) begin
            if (phase_end(hcnt_reg, 1'b0, hph_reg)) begin
                hcnt_next = '0;
                hph_next  = phase_step(hph_reg);
                if (hph_reg == vst_pkg::VST_PH_FRONT) begin
                    if (phase_end(vcnt_reg, 1'b1, vph_reg)) begin
                        vcnt_next = '0;
                        vph_next  = phase_step(vph_reg);
                    end else begin
                        vcnt_next = vcnt_reg + CW'(1);
                    end
                end
            end else begin
                hcnt_next = hcnt_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            div_reg  <= '0;
            hph_reg  <= vst_pkg::VST_PH_SYNC;
            vph_reg  <= vst_pkg::VST_PH_SYNC;
            hcnt_reg <= '0;
            vcnt_reg <= '0;
        end else begin
            div_reg  <= div_next;
            hph_reg  <= hph_next;
            vph_reg  <= vph_next;
            hcnt_reg <= hcnt_next;
            vcnt_reg <= vcnt_next;
        end
    end

    // Output stage: it reads the beam state before that moves, so every video
    // output changes together on the same pixel edge.
    always_comb begin
        hsync_next = hsync_reg;
        vsync_next = vsync_reg;
        rgb_next   = rgb_reg;
        hpos_next  = hpos_reg;
        vpos_next  = vpos_reg;
        act_next   = act_reg;
        fs_next    = 1'b0;
        und_next   = 1'b0;
        if (pix_en) begin
            hsync_next = (hph_reg != vst_pkg::VST_PH_SYNC);
            vsync_next = (vph_reg != vst_pkg::VST_PH_SYNC);
            rgb_next   = (vis && out_if.valid) ? out_if.data : '0;
            hpos_next  = (hph_reg == vst_pkg::VST_PH_VIS) ? hcnt_reg : '0;
            vpos_next  = (vph_reg == vst_pkg::VST_PH_VIS) ? vcnt_reg : '0;
            act_next   = vis;
            fs_next    = vis && (hcnt_reg == '0) && (vcnt_reg == '0);
            // An empty FIFO on screen shows black rather than stale colour.
            und_next   = vis && !out_if.valid;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hsync_reg <= vst_pkg::SYNC_IDLE;
            vsync_reg <= vst_pkg::SYNC_IDLE;
            rgb_reg   <= '0;
            hpos_reg  <= '0;
            vpos_reg  <= '0;
            act_reg   <= 1'b0;
            fs_reg    <= 1'b0;
            und_reg   <= 1'b0;
        end else begin
            hsync_reg <= hsync_next;
            vsync_reg <= vsync_next;
            rgb_reg   <= rgb_next;
            hpos_reg  <= hpos_next;
            vpos_reg  <= vpos_next;
            act_reg   <= act_next;
            fs_reg    <= fs_next;
            und_reg   <= und_next;
        end
    end

    assign hsync_n_o     = hsync_reg;
    assign vsync_n_o     = vsync_reg;
    assign red_o         = rgb_reg[DW-1 -: COLOR_W];
    assign green_o       = rgb_reg[COLOR_W +: COLOR_W];
    assign blue_o        = rgb_reg[0 +: COLOR_W];
    assign h_pos_o       = hpos_reg;
    assign v_pos_o       = vpos_reg;
    assign active_o      = act_reg;
    assign frame_start_o = fs_reg;
    assign underrun_o    = und_reg;
endmodule : vst_sync_gen
`default_nettype wire

// ### tb/vst_sync_gen_monitor.sv
// Concurrent checks on the sync generator's video outputs.
// Assumes the 805 by 525 pixel raster at four clocks per pixel.
`timescale 1ns/1ps
`default_nettype none
module vst_sync_gen_monitor #(
    parameter int COLOR_W = 1
) (
    input wire logic                       ref_clk_i,
    input wire logic                       rst_n_i,
    input wire logic                       hsync_n_o,
    input wire logic                       vsync_n_o,
    input wire logic [COLOR_W-1:0]         red_o,
    input wire logic [COLOR_W-1:0]         green_o,
    input wire logic [COLOR_W-1:0]         blue_o,
    input wire logic [vst_pkg::CNT_W-1:0]  h_pos_o,
    input wire logic [vst_pkg::CNT_W-1:0]  v_pos_o,
    input wire logic                       active_o,
    input wire logic                       frame_start_o,
    input wire logic                       underrun_o
);
    logic [15:0] hl_reg;
    logic [15:0] vl_reg;
    logic [15:0] lc_reg;
    logic        ok_reg;
    wire logic   dark = (red_o == '0) && (green_o == '0) && (blue_o == '0);

    // The count before the first hsync fall starts at reset, not at a fall, so ok_reg masks it.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hl_reg <= 16'h0;
            vl_reg <= 16'h0;
            lc_reg <= 16'h0;
            ok_reg <= 1'b0;
        end else begin
            hl_reg <= hsync_n_o ? 16'h0 : hl_reg + 16'h1;
            vl_reg <= vsync_n_o ? 16'h0 : vl_reg + 16'h1;
            lc_reg <= $fell(hsync_n_o) ? 16'h1 : lc_reg + 16'h1;
            ok_reg <= ok_reg | $fell(hsync_n_o);
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_hs_width; $rose(hsync_n_o) && ok_reg |-> hl_reg == 16'h0178; endproperty
    a_hs_width: assert property (p_hs_width) else $error("hsync width");
    property p_line; $fell(hsync_n_o) && ok_reg |-> lc_reg == 16'h0c94; endproperty
    a_line: assert property (p_line) else $error("line length");
    property p_vs_width; $rose(vsync_n_o) && ok_reg |-> vl_reg == 16'h1928; endproperty
    a_vs_width: assert property (p_vs_width) else $error("vsync width");
    property p_vs_align; $fell(vsync_n_o) |-> $fell(hsync_n_o); endproperty
    a_vs_align: assert property (p_vs_align) else $error("vsync align");
    property p_sync_dark; !hsync_n_o || !vsync_n_o |-> dark && !active_o; endproperty
    a_sync_dark: assert property (p_sync_dark) else $error("colour in sync");
    property p_blank; !active_o |-> dark; endproperty
    a_blank: assert property (p_blank) else $error("colour off screen");
    // Columns keep counting on blank rows, so only a visible row pins h_pos to zero.
    property p_col_blank; !active_o && v_pos_o != '0 |-> h_pos_o == '0; endproperty
    a_col_blank: assert property (p_col_blank) else $error("column off screen");
    property p_origin; frame_start_o |-> active_o && h_pos_o == '0 && v_pos_o == '0; endproperty
    a_origin: assert property (p_origin) else $error("frame origin");
    property p_step; active_o && $past(active_o) && $changed(h_pos_o)
        |-> h_pos_o == $past(h_pos_o) + 1'b1; endproperty
    a_step: assert property (p_step) else $error("column step");
    property p_hold; active_o && $changed(h_pos_o) |=> $stable(h_pos_o) [*3]; endproperty
    a_hold: assert property (p_hold) else $error("pixel slot");
    property p_under; underrun_o |-> active_o && dark; endproperty
    a_under: assert property (p_under) else $error("underrun colour");
endmodule : vst_sync_gen_monitor

bind vst_sync_gen vst_sync_gen_monitor #(.COLOR_W(COLOR_W)) u_mon (
    .ref_clk_i, .rst_n_i, .hsync_n_o, .vsync_n_o, .red_o, .green_o, .blue_o,
    .h_pos_o, .v_pos_o, .active_o, .frame_start_o, .underrun_o
);
`default_nettype wire

// ### tb/vst_vga_display.sv
// Behavioural display that measures line, sync and row timing.
// Assumes syncs change just after the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module vst_vga_display (
    input  wire logic        clk_i,
    input  wire logic        hsync_n_i,
    input  wire logic        vsync_n_i,
    output logic      [15:0] row_o = 16'h0,
    output logic      [15:0] line_o = 16'h0,
    output logic      [15:0] hs_low_o = 16'h0,
    output logic      [15:0] vs_rows_o = 16'h0
);
    logic [15:0] cnt  = 16'h0;
    logic [15:0] low  = 16'h0;
    logic        hs_q = 1'b1;
    logic        vs_q = 1'b1;

    always @(posedge clk_i) begin
        hs_q <= hsync_n_i;
        vs_q <= vsync_n_i;
        cnt  <= cnt + 16'h1;
        low  <= hsync_n_i ? 16'h0 : low + 16'h1;
        if (hsync_n_i && !hs_q) begin
            hs_low_o <= low;
        end
        if (!hsync_n_i && hs_q) begin
            line_o <= cnt;
            cnt    <= 16'h1;
            row_o  <= row_o + 16'h1;
        end
        if (!vsync_n_i && vs_q) begin
            row_o <= 16'h0;
        end
        // Row 0 starts at the falling edge, so the rows under the pulse are row_o plus one.
        if (vsync_n_i && !vs_q) begin
            vs_rows_o <= row_o + 16'h1;
        end
    end
endmodule : vst_vga_display
`default_nettype wire

// ### tb/tb_top.sv
// Bench: fills the pixel buffer, checks sync timing and the first pixels.
// Assumes the default of one colour bit and an 8-word buffer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk_i   = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic [2:0]  pix_data_i  = 3'h0;
    logic        pix_valid_i = 1'b0;
    logic        pix_ready_o, hsync_n_o, vsync_n_o, red_o, green_o, blue_o;
    logic        active_o, frame_start_o, underrun_o;
    logic [9:0]  h_pos_o, v_pos_o;
    logic [15:0] row, line_clks, hs_low, vs_rows;
    wire  [15:0] rgb = {13'h0, red_o, green_o, blue_o};
    wire  [15:0] hp  = {6'h0, h_pos_o};
    int          failures = 0;
    int          compares = 0;
    int          cycles   = 0;

    vst_sync_gen uut (
        .ref_clk_i, .rst_n_i, .pix_data_i, .pix_valid_i, .pix_ready_o, .hsync_n_o,
        .vsync_n_o, .red_o, .green_o, .blue_o, .h_pos_o, .v_pos_o, .active_o,
        .frame_start_o, .underrun_o
    );
    vst_vga_display u_disp (
        .clk_i(ref_clk_i), .hsync_n_i(hsync_n_o), .vsync_n_i(vsync_n_o),
        .row_o(row), .line_o(line_clks), .hs_low_o(hs_low), .vs_rows_o(vs_rows)
    );

    initial forever #5 ref_clk_i = ~ref_clk_i;

    task automatic wrap_up;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    task automatic t_reset;
        tick(9);
        chk(16'({hsync_n_o, vsync_n_o, pix_ready_o}), 16'h7);
        chk(rgb, 16'h0);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        $display("t_reset done");
    endtask : t_reset

    // The ninth word is offered while the buffer is full and must never be shown.
    task automatic t_fill;
        pix_valid_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            pix_data_i <= 3'(i + 1);
            do @(posedge ref_clk_i); while (pix_ready_o !== 1'b1);
        end
        pix_data_i <= 3'h7;
        repeat (3) @(posedge ref_clk_i);
        chk(16'(pix_ready_o), 16'h0);
        pix_valid_i <= 1'b0;
        $display("t_fill done");
    endtask : t_fill

    task automatic t_sync;
        tick(9660);
        chk(line_clks, 16'h0c94);
        chk(hs_low, 16'h0178);
        chk(vs_rows, 16'h0002);
        chk(row, 16'h0003);
        chk(16'(vsync_n_o), 16'h1);
        $display("t_sync done");
    endtask : t_sync

    task automatic t_frame;
        for (int n = 0; n < 120000 && frame_start_o !== 1'b1; n++) tick(1);
        chk(row, 16'h0022);
        chk(rgb, 16'h1);
        for (int i = 1; i < 9; i++) begin
            tick(4);
            chk(hp, 16'(i));
            chk(rgb, (i < 8) ? 16'((i + 1) % 8) : 16'h0);
        end
        chk(16'({active_o, underrun_o}), 16'h3);
        $display("t_frame done");
    endtask : t_frame

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 130000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        t_reset();
        t_fill();
        t_sync();
        t_frame();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
